/* File: design/boot_loader_pkg.sv */
package boot_loader_pkg;

  // =====================================================================
  // flash geometry
  localparam int unsigned PAGE_BYTES      = 256;
  localparam int unsigned PAGE_COUNT      = 8192;
  localparam int unsigned ADDR_BYTES      = 3;
  localparam int unsigned SECTOR_BYTES    = 4096;
  localparam int unsigned ID_BYTES        = 3;
  localparam int unsigned ID_DUMMY_BYTES  = 0;
  localparam int unsigned QREAD_DUMMY     = 1;

  // =====================================================================
  // flash opcodes
  localparam logic [7:0] OP_READ_ID       = 8'h9f;
  localparam logic [7:0] OP_SECTOR_ERASE  = 8'h20;
  localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_PAGE_PROGRAM  = 8'h02;
  localparam logic [7:0] OP_QUAD_READ     = 8'heb;
  localparam logic [7:0] OP_READ_STATUS   = 8'h05;
  localparam logic [7:0] OP_WRITE_STATUS  = 8'h01;
  localparam logic [7:0] BUSY_MASK        = 8'h01;

  // =====================================================================
  // image start address and slot bases
  localparam logic [23:0] IMAGE_BASE      = 24'h000000;
  localparam logic [23:0] UPGRADE_BASE    = 24'h100000;

  // =====================================================================
  // timing
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned SCK_HALF_NS     = 40;
  localparam int unsigned SCK_HALF_CYC    =
    (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // =====================================================================
  // reset values
  localparam logic        CS_IDLE         = 1'b1;
  localparam logic        SCK_IDLE        = 1'b0;

endpackage : boot_loader_pkg

/* File: design/sync_two_stage.sv */
`timescale 1ns/1ns

// two flip-flop synchroniser for a bundle of pin levels
module sync_two_stage #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  if (WIDTH < 1) begin : g_width_check
    $error("sync_two_stage width must be at least one");
  end

  // =====================================================================
  // first stage feeds only the second
  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;

endmodule : sync_two_stage

/* File: design/slave_byte_rx.sv */
`timescale 1ns/1ns

// spi slave receiver, mode 0, msb first, runs on synchronised pins
module slave_byte_rx (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       enable,
  input  wire logic       sck_s,
  input  wire logic       cs_n_s,
  input  wire logic       mosi_s,
  output logic            byte_valid,
  output logic [7:0]      byte_data,
  output logic            miso_o
);

  logic       sck_d_reg;
  logic       sck_d_next;
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic [2:0] count_reg;
  logic [2:0] count_next;
  logic       valid_reg;
  logic       valid_next;
  logic [7:0] data_reg;
  logic [7:0] data_next;
  logic       rise;

  // =====================================================================
  // sample mosi on rising sck while selected
  always_comb begin
    rise       = sck_s && !sck_d_reg;
    sck_d_next = sck_s;
    shift_next = shift_reg;
    count_next = count_reg;
    valid_next = 1'b0;
    data_next  = data_reg;
    if (!enable || cs_n_s) begin
      count_next = 3'h0;                          // frame end drops partial byte
    end else if (rise) begin
      shift_next = {shift_reg[6:0], mosi_s};
      count_next = 3'(count_reg + 3'h1);
      if (count_reg == 3'h7) begin
        valid_next = 1'b1;
        data_next  = {shift_reg[6:0], mosi_s};
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sck_d_reg <= 1'b0;
      shift_reg <= 8'h00;
      count_reg <= 3'h0;
      valid_reg <= 1'b0;
      data_reg  <= 8'h00;
    end else begin
      sck_d_reg <= sck_d_next;
      shift_reg <= shift_next;
      count_reg <= count_next;
      valid_reg <= valid_next;
      data_reg  <= data_next;
    end
  end

  assign byte_valid = valid_reg;
  assign byte_data  = data_reg;
  assign miso_o     = 1'b0;                       // boot stream is receive only

endmodule : slave_byte_rx

/* File: design/boot_image_loader.sv */
`timescale 1ns/1ns

// Operation
// - boot sequence runs after every start-up and every reset
// - strap high at start-up selects spi slave boot
// - strap tied to flash data line one selects quad master boot
// - slave mode: clock, select, mosi are inputs; only miso driven
// - flash clock pin driven in master mode, input in slave mode
// - master boot starts with read command at address zero; with an upgrade image in use the code reads from 0x100000
// - each image byte crosses quad lines low nibble first; address and mode bytes go out high nibble first
// - flash has 256-byte pages, 8192 pages, 3-byte addresses
// - read id uses 0x9f, no dummy bytes, three id bytes
// - sector erase uses 0x20 on uniform 4 kB sectors
// - write enable 0x06, write disable 0x04
// - page program uses 0x02
// - quad read uses 0xeb with one dummy byte after setup
// - busy tested via status read 0x05 and mask 0x01
// - status register write uses 0x01
// - failed upgrade falls back to factory image
// - removed upgrade image reverts boot to factory image
// - switch to factory image takes effect only at next reboot; reset clears pend_reg, so code needs failed or remove still high after reset
// - held in reset while supplies ramp; boot after release
module boot_image_loader #(
  parameter int unsigned IMAGE_BYTES = 4096
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        upgrade_present,
  input  wire logic        upgrade_failed,
  input  wire logic        upgrade_remove,
  input  wire logic        flash_clk_i,
  output logic             flash_clk_o,
  output logic             flash_clk_oe_n,
  input  wire logic        flash_cs_n_i,
  output logic             flash_cs_n_o,
  output logic             flash_cs_n_oe_n,
  input  wire logic        flash_data_line_zero_i,
  output logic             flash_data_line_zero_o,
  output logic             flash_data_line_zero_oe_n,
  input  wire logic        flash_data_line_one_i,
  output logic             flash_data_line_one_o,
  output logic             flash_data_line_one_oe_n,
  input  wire logic        flash_data_line_two_i,
  output logic             flash_data_line_two_o,
  output logic             flash_data_line_two_oe_n,
  input  wire logic        flash_data_line_three_i,
  output logic             flash_data_line_three_o,
  output logic             flash_data_line_three_oe_n,
  input  wire logic        spi_mosi,
  output logic             spi_miso,
  output logic             image_valid,
  output logic [7:0]       image_data,
  output logic             boot_slave_mode,
  output logic             boot_done,
  output logic             boot_factory
);

  typedef enum logic [2:0] {
    ST_STRAP = 3'b000,
    ST_CMD   = 3'b001,
    ST_ADDR  = 3'b010,
    ST_DUMMY = 3'b011,
    ST_DATA  = 3'b100,
    ST_SLAVE = 3'b101,
    ST_DONE  = 3'b110
  } state_e;

  localparam int unsigned CNT_W = $clog2(IMAGE_BYTES + 1) + 1;

  if (IMAGE_BYTES < 1 || IMAGE_BYTES > boot_loader_pkg::PAGE_BYTES
      * boot_loader_pkg::PAGE_COUNT) begin : g_size_check
    $error("image size out of flash range");
  end

  // =====================================================================
  // pin synchronisers
  logic [4:0] pins_s;
  logic       sck_s;
  logic       cs_s;
  logic       mosi_s;
  logic [3:0] dq_s;

  sync_two_stage #(.WIDTH(5)) u_sync_ctl (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in ({flash_clk_i, flash_cs_n_i, spi_mosi, flash_data_line_zero_i,
                flash_data_line_two_i}),
    .sync_out (pins_s)
  );

  sync_two_stage #(.WIDTH(2)) u_sync_dq (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in ({flash_data_line_three_i, flash_data_line_one_i}),
    .sync_out ({dq_s[3], dq_s[1]})
  );

  assign sck_s   = pins_s[4];
  assign cs_s    = pins_s[3];
  assign mosi_s  = pins_s[2];
  assign dq_s[0] = pins_s[1];
  assign dq_s[2] = pins_s[0];

  // =====================================================================
  // state registers
  state_e          state_reg,  state_next;
  logic            mode_reg,   mode_next;
  logic [1:0]      settle_reg, settle_next;
  logic            factory_reg, factory_next;
  logic            pend_reg,   pend_next;
  logic [2:0]      half_reg,   half_next;
  logic            sck_reg,    sck_next;
  logic            cs_reg,     cs_next;
  logic [5:0]      bit_reg,    bit_next;
  logic [31:0]     sh_reg,     sh_next;
  logic [7:0]      rx_reg,     rx_next;
  logic            nib_reg,    nib_next;
  logic [CNT_W-1:0] cnt_reg,   cnt_next;
  logic            val_reg,    val_next;
  logic [7:0]      dat_reg,    dat_next;
  logic            srx_valid;
  logic [7:0]      srx_data;
  logic            srx_miso;
  logic            tick;
  logic            fall;

  slave_byte_rx u_slave (
    .clk        (clk),
    .reset_n    (reset_n),
    .enable     (state_reg == ST_SLAVE),
    .sck_s      (sck_s),
    .cs_n_s     (cs_s),
    .mosi_s     (mosi_s),
    .byte_valid (srx_valid),
    .byte_data  (srx_data),
    .miso_o     (srx_miso)
  );

  // =====================================================================
  // boot sequencer next state
  always_comb begin
    state_next   = state_reg;
    mode_next    = mode_reg;
    settle_next  = settle_reg;
    factory_next = factory_reg;
    pend_next    = pend_reg;
    half_next    = half_reg;
    sck_next     = sck_reg;
    cs_next      = cs_reg;
    bit_next     = bit_reg;
    sh_next      = sh_reg;
    rx_next      = rx_reg;
    nib_next     = nib_reg;
    cnt_next     = cnt_reg;
    val_next     = 1'b0;
    dat_next     = dat_reg;
    tick         = (half_reg == 3'(boot_loader_pkg::SCK_HALF_CYC - 1));
    fall         = tick && sck_reg;
    // upgrade events latch into pend_reg, which reset clears; read only at the strap latch
    if (upgrade_failed || upgrade_remove)
      pend_next = 1'b1;
    if (state_reg != ST_STRAP && state_reg != ST_SLAVE && state_reg != ST_DONE)
      half_next = tick ? 3'h0 : 3'(half_reg + 3'h1);
    case (state_reg)
      ST_STRAP: begin
        // wait for synchroniser to carry the strap, then latch once
        settle_next = 2'(settle_reg + 2'h1);
        if (settle_reg == 2'h3) begin
          mode_next    = dq_s[1];
          factory_next = !upgrade_present || upgrade_failed || upgrade_remove
                         || pend_reg;
          if (dq_s[1]) begin
            state_next = ST_SLAVE;
          end else begin
            state_next = ST_CMD;
            cs_next    = 1'b0;
            sh_next    = {boot_loader_pkg::OP_QUAD_READ, 24'h000000};
            bit_next   = 6'h0;
          end
        end
      end
      ST_CMD: begin
        if (tick) sck_next = !sck_reg;
        if (fall) begin
          sh_next  = {sh_reg[30:0], 1'b0};
          bit_next = 6'(bit_reg + 6'h1);
          if (bit_reg == 6'h7) begin
            state_next = ST_ADDR;
            bit_next   = 6'h0;
            sh_next    = {factory_reg ? boot_loader_pkg::IMAGE_BASE
                                      : boot_loader_pkg::UPGRADE_BASE, 8'h00};
          end
        end
      end
      ST_ADDR: begin
        // 24 address bits then mode byte, four bits a clock
        if (tick) sck_next = !sck_reg;
        if (fall) begin
          sh_next  = {sh_reg[27:0], 4'h0};
          bit_next = 6'(bit_reg + 6'h1);
          if (bit_reg == 6'h7) begin
            state_next = ST_DUMMY;
            bit_next   = 6'h0;
          end
        end
      end
      ST_DUMMY: begin
        if (tick) sck_next = !sck_reg;
        if (fall) begin
          bit_next = 6'(bit_reg + 6'h1);
          if (bit_reg == 6'(2 * boot_loader_pkg::QREAD_DUMMY - 1)) begin
            state_next = ST_DATA;
            nib_next   = 1'b0;
          end
        end
      end
      ST_DATA: begin
        if (tick) sck_next = !sck_reg;
        if (tick && !sck_reg) begin
          // rising edge: low nibble arrives first
          nib_next = !nib_reg;
          if (!nib_reg) begin
            rx_next[3:0] = dq_s;
          end else begin
            val_next = 1'b1;
            dat_next = {dq_s, rx_reg[3:0]};
            cnt_next = CNT_W'(cnt_reg + 1'b1);
            if (cnt_reg == CNT_W'(IMAGE_BYTES - 1)) begin
              state_next = ST_DONE;
              cs_next    = 1'b1;
              sck_next   = 1'b0;
            end
          end
        end
      end
      ST_SLAVE: begin
        if (srx_valid) begin
          val_next = 1'b1;
          dat_next = srx_data;
          cnt_next = CNT_W'(cnt_reg + 1'b1);
          if (cnt_reg == CNT_W'(IMAGE_BYTES - 1)) state_next = ST_DONE;
        end
      end
      ST_DONE: begin
        state_next = ST_DONE;
      end
      default: begin
        state_next = ST_STRAP;
      end
    endcase
  end

  // =====================================================================
  // state registers, reset starts a new boot
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg   <= ST_STRAP;
      mode_reg    <= 1'b0;
      settle_reg  <= 2'h0;
      factory_reg <= 1'b1;
      pend_reg    <= 1'b0;
      half_reg    <= 3'h0;
      sck_reg     <= boot_loader_pkg::SCK_IDLE;
      cs_reg      <= boot_loader_pkg::CS_IDLE;
      bit_reg     <= 6'h0;
      sh_reg      <= 32'h0000_0000;
      rx_reg      <= 8'h00;
      nib_reg     <= 1'b0;
      cnt_reg     <= '0;
      val_reg     <= 1'b0;
      dat_reg     <= 8'h00;
    end else begin
      state_reg   <= state_next;
      mode_reg    <= mode_next;
      settle_reg  <= settle_next;
      factory_reg <= factory_next;
      pend_reg    <= pend_next;
      half_reg    <= half_next;
      sck_reg     <= sck_next;
      cs_reg      <= cs_next;
      bit_reg     <= bit_next;
      sh_reg      <= sh_next;
      rx_reg      <= rx_next;
      nib_reg     <= nib_next;
      cnt_reg     <= cnt_next;
      val_reg     <= val_next;
      dat_reg     <= dat_next;
    end
  end

  // =====================================================================
  // pin drive; slave mode releases clock, select and data lines
  logic master;
  logic quad_out;
  assign master   = (state_reg != ST_STRAP) && !mode_reg;
  assign quad_out = master && (state_reg == ST_ADDR);

  assign flash_clk_o                = sck_reg;
  assign flash_clk_oe_n             = !master;
  assign flash_cs_n_o               = cs_reg;
  assign flash_cs_n_oe_n            = !master;
  assign flash_data_line_zero_o     = (state_reg == ST_CMD) ? sh_reg[31] : sh_reg[28];
  assign flash_data_line_zero_oe_n  = !(quad_out || (master && state_reg == ST_CMD));
  assign flash_data_line_one_o      = sh_reg[29];
  assign flash_data_line_one_oe_n   = !quad_out;
  assign flash_data_line_two_o      = sh_reg[30];
  assign flash_data_line_two_oe_n   = !quad_out;
  assign flash_data_line_three_o    = sh_reg[31];
  assign flash_data_line_three_oe_n = !quad_out;
  assign spi_miso                   = srx_miso;
  assign image_valid                = val_reg;
  assign image_data                 = dat_reg;
  assign boot_slave_mode            = mode_reg;
  assign boot_done                  = (state_reg == ST_DONE);
  assign boot_factory               = factory_reg;

  // =====================================================================
  // checks
  strap_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    (state_reg != ST_STRAP) |=> $stable(mode_reg))
    else $error("boot mode changed after strap latch");
  cs_frame_a: assert property (@(posedge clk) disable iff (!reset_n)
    (state_reg inside {ST_CMD, ST_ADDR, ST_DUMMY, ST_DATA}) |-> !cs_reg)
    else $error("chip select high inside frame");
  slave_noclk_a: assert property (@(posedge clk) disable iff (!reset_n)
    mode_reg && state_reg != ST_STRAP |-> flash_clk_oe_n && flash_cs_n_oe_n)
    else $error("clock driven in slave mode");
  opcode_a: assert property (@(posedge clk) disable iff (!reset_n)
    (state_reg == ST_STRAP && state_next == ST_CMD) |=>
      sh_reg[31:24] == 8'heb)
    else $error("wrong read opcode");
  nibble_a: assert property (@(posedge clk) disable iff (!reset_n)
    (state_reg == ST_DATA && val_next) |=> image_data[3:0] == $past(rx_reg[3:0]))
    else $error("nibble order wrong");
  factory_a: assert property (@(posedge clk) disable iff (!reset_n)
    (state_reg != ST_STRAP) |=> $stable(factory_reg))
    else $error("image slot changed before reboot");
  start_a: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(reset_n) |-> state_reg == ST_STRAP)
    else $error("boot did not restart");
  miso_only_a: assert property (@(posedge clk) disable iff (!reset_n)
    mode_reg |-> flash_data_line_zero_oe_n && flash_data_line_one_oe_n)
    else $error("flash lines driven in slave mode");

  master_c: cover property (@(posedge clk) state_reg == ST_DATA ##1 state_reg == ST_DONE);
  slave_c:  cover property (@(posedge clk) state_reg == ST_SLAVE && srx_valid);
  fallback_c: cover property (@(posedge clk) upgrade_failed && state_reg == ST_DONE);

endmodule : boot_image_loader

/* File: tb/quad_flash_model.sv */
`timescale 1ns/1ns

// quad flash partner answering the fast quad read only
module quad_flash_model (
  input  wire logic        sck,
  input  wire logic        cs_n,
  input  wire logic [3:0]  qin,
  output logic      [3:0]  q,
  output logic             q_oe,
  output logic      [7:0]  opcode,
  output logic      [23:0] addr,
  output int               rises
);
  int          k;
  logic [23:0] a;
  logic [7:0]  b;

  // =====================================================================
  // frame start and end
  initial begin
    q = 4'h0;
    q_oe = 1'b0;
    opcode = 8'h00;
    addr = 24'h000000;
    rises = 0;
  end
  always @(negedge cs_n) begin
    rises = 0;
  end
  always @(posedge cs_n) begin
    q_oe = 1'b0; // lines let go between frames
  end

  // =====================================================================
  // opcode and address capture on sck rise
  always @(posedge sck) begin
    if (!cs_n) begin
      rises = rises + 1;
      if (rises <= 8) begin
        opcode = {opcode[6:0], qin[0]}; // single line, msb first
      end else if (rises <= 14) begin
        addr = {addr[19:0], qin}; // three address bytes
      end
    end
  end

  // =====================================================================
  // data after mode byte and dummy byte, low nibble first
  always @(negedge sck) begin
    if (!cs_n && rises >= 18) begin // one dummy byte before data
      k = rises - 18;
      a = addr + 24'(k / 2);
      b = a[7:0] + a[23:16] + 8'h3c; // full 24-bit space, over two megabytes
      q = k[0] ? b[7:4] : b[3:0]; // low nibble first
      q_oe = 1'b1; // quad lines enabled as if programmed so
    end
  end
endmodule : quad_flash_model

/* File: tb/boot_image_loader_tb.sv */
`timescale 1ns/1ns

// self-checking bench for the boot image loader
module boot_image_loader_tb;
  localparam int IMG = 4;

  logic       clk = 1'b0;
  logic       reset_n = 1'b0;
  logic       strap = 1'b0;
  logic       present = 1'b0;
  logic       failed = 1'b0;
  logic       remove = 1'b0;
  logic       s_sck = 1'b0;
  logic       s_cs_n = 1'b1;
  logic       s_mosi = 1'b0;
  logic       clk_o, clk_oe_n, cs_o, cs_oe_n, miso, valid, slave, done, factory;
  logic [3:0] d_o, d_oe_n, fq, line;
  logic       fq_oe;
  logic [7:0] data, op;
  logic [23:0] fa;
  int         rises;
  int         miscompares = 0;
  int         compares = 0;
  logic [7:0] got[$];

  // =====================================================================
  // clock and pin resolution
  always #5 clk = ~clk; // clock already running as reset releases
  for (genvar i = 0; i < 4; i++) begin : g_line
    assign line[i] = !d_oe_n[i] ? d_o[i] : fq_oe ? fq[i] : (i == 1) ? strap : 1'b1;
  end
  always @(posedge clk) begin
    if (valid === 1'b1) begin
      got.push_back(data);
    end
  end

  boot_image_loader #(.IMAGE_BYTES(IMG)) DUT (
    .clk(clk), .reset_n(reset_n), .upgrade_present(present), .upgrade_failed(failed),
    .upgrade_remove(remove), .flash_clk_i(!clk_oe_n ? clk_o : s_sck), .flash_clk_o(clk_o),
    .flash_clk_oe_n(clk_oe_n), .flash_cs_n_i(!cs_oe_n ? cs_o : s_cs_n),
    .flash_cs_n_o(cs_o), .flash_cs_n_oe_n(cs_oe_n),
    .flash_data_line_zero_i(line[0]), .flash_data_line_zero_o(d_o[0]),
    .flash_data_line_zero_oe_n(d_oe_n[0]), .flash_data_line_one_i(line[1]),
    .flash_data_line_one_o(d_o[1]), .flash_data_line_one_oe_n(d_oe_n[1]),
    .flash_data_line_two_i(line[2]), .flash_data_line_two_o(d_o[2]),
    .flash_data_line_two_oe_n(d_oe_n[2]), .flash_data_line_three_i(line[3]),
    .flash_data_line_three_o(d_o[3]), .flash_data_line_three_oe_n(d_oe_n[3]),
    .spi_mosi(s_mosi), .spi_miso(miso), .image_valid(valid), .image_data(data),
    .boot_slave_mode(slave), .boot_done(done), .boot_factory(factory));

  quad_flash_model flash (
    .sck(!clk_oe_n ? clk_o : 1'b0), .cs_n(!cs_oe_n ? cs_o : 1'b1), .qin(line),
    .q(fq), .q_oe(fq_oe), .opcode(op), .addr(fa), .rises(rises));

  // =====================================================================
  // shared tasks
  task automatic end_sim;
    if (miscompares == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic do_reset(input logic s, input logic p);
    got.delete();
    @(posedge clk);
    reset_n <= 1'b0;
    strap <= s;
    present <= p;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
  endtask : do_reset

  task automatic wait_done;
    int n;
    for (n = 0; n < 5000 && done !== 1'b1; n++) begin
      @(posedge clk);
    end
    if (done !== 1'b1) begin
      check("boot done wait", 32'h0, 32'h1);
      end_sim();
    end
    repeat (2) @(posedge clk);
  endtask : wait_done

  task automatic spi_bit(input logic b);
    s_mosi <= b;
    repeat (4) @(posedge clk);
    s_sck <= 1'b1;
    repeat (4) @(posedge clk);
    s_sck <= 1'b0;
  endtask : spi_bit

  // =====================================================================
  // scenarios
  task automatic master_boot(input logic p);
    logic [23:0] base;
    logic [23:0] a;
    logic        fac;
    do_reset(1'b0, p);
    fac  = !p || failed || remove; // no upgrade, or a failed or removed one
    base = fac ? boot_loader_pkg::IMAGE_BASE : boot_loader_pkg::UPGRADE_BASE;
    wait_done();
    check("opcode", 32'(op), 32'(boot_loader_pkg::OP_QUAD_READ));
    check("start address", 32'(fa), 32'(base));
    check("factory slot", 32'(factory), 32'(fac));
    check("slave mode", 32'(slave), 32'h0);
    check("clock enable", 32'(clk_oe_n), 32'h0);
    check("byte count", got.size(), IMG);
    for (int i = 0; i < IMG; i++) begin
      a = base + 24'(i);
      check("image byte", 32'(got[i]), 32'(8'(a[7:0] + a[23:16] + 8'h3c)));
    end
    check("select idle", 32'(cs_o), 32'h1);
    // last nibble is read as the clock would rise, so that rise is not sent
    check("whole frame", 32'(rises), 32'(17 + 2 * IMG));
  endtask : master_boot

  task automatic upgrade_events;
    master_boot(1'b1);
    failed <= 1'b1;
    repeat (40) @(posedge clk);
    check("slot kept", 32'(factory), 32'h0);
    check("no refetch", 32'(cs_o), 32'h1);
    master_boot(1'b1); // failed upgrade falls back at reboot
    failed <= 1'b0;
    remove <= 1'b1;
    master_boot(1'b1); // removed upgrade reverts to factory image
    remove <= 1'b0;
  endtask : upgrade_events

  task automatic slave_boot;
    logic [7:0] img[4] = '{8'ha5, 8'h3c, 8'h0f, 8'hf0};
    do_reset(1'b1, 1'b0);
    repeat (12) @(posedge clk);
    strap <= 1'b0; // strap moves after latch
    s_cs_n <= 1'b0;
    repeat (3) spi_bit(1'b1); // partial byte dropped
    s_cs_n <= 1'b1;
    repeat (8) @(posedge clk);
    s_cs_n <= 1'b0;
    for (int i = 0; i < IMG; i++) begin
      for (int j = 7; j >= 0; j--) begin
        spi_bit(img[i][j]);
      end
    end
    repeat (8) @(posedge clk);
    s_cs_n <= 1'b1;
    wait_done();
    check("slave mode", 32'(slave), 32'h1);
    check("clock pin input", 32'(clk_oe_n), 32'h1);
    check("select pin input", 32'(cs_oe_n), 32'h1);
    check("data lines released", 32'(d_oe_n), 32'hf);
    check("miso idle", 32'(miso), 32'h0);
    check("byte count", got.size(), IMG);
    for (int i = 0; i < IMG; i++) begin
      check("slave byte", 32'(got[i]), 32'(img[i]));
    end
  endtask : slave_boot

  // =====================================================================
  // main sequence
  initial begin
    master_boot(1'b0);
    upgrade_events();
    slave_boot();
    master_boot(1'b0);
    end_sim();
  end
endmodule : boot_image_loader_tb
